// [bench/control_store_model.sv]
// behavioural control store with its pipeline register
// assumes the sequencer address has settled before each rising edge
`timescale 1ns/1ns
module control_store_model (
	// clock
	input wire logic core_clk,
	// address from the sequencer
	input wire logic [seq_pkg::ADDR_W-1:0] addr,
	// registered microword
	output logic [2*seq_pkg::ADDR_W-1:0] pipeWord
);
	// ********
	// storage and pipeline
	// ********
	// pattern of the address, so every location reads back as something checkable
	always_ff @(posedge core_clk) begin
		pipeWord <= {~addr, addr};
	end
endmodule

// [bench/microprogram_address_sequencer_tb.sv]
// self-checking bench for the microprogram address sequencer
// assumes the control store model sits on the address output
`timescale 1ns/1ns
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
	$display("wrong value %s expected %h seen %h", nm, e, s); end end
module microprogram_address_sequencer_tb;
	typedef struct packed {logic [1:0] s; logic c; logic ld; logic [15:0] d; logic [15:0] e;} row_t;
	logic core_clk = 0;
	logic rstn = 0;
	seq_pkg::src_sel_t srcSel = seq_pkg::SRC_COUNTER;
	seq_pkg::stk_op_t stackOp = seq_pkg::STK_HOLD;
	logic condPass = 0, branchTaken = 0, regLoad = 0, regDecr = 0;
	logic [15:0] directAddr = 16'h0000;
	logic [15:0] nextAddr, stackTop;
	logic regZero, stackFull, stackEmpty;
	logic [31:0] pipeWord;
	int n_mismatch = 0;
	int cmp_count = 0;
	row_t rows [7] = '{
		'{1, 1, 0, 16'h1234, 16'h1234}, '{0, 1, 0, 16'h0000, 16'h1235},
		'{1, 0, 0, 16'h5555, 16'h1236}, '{1, 1, 1, 16'hFFFF, 16'hFFFF},
		'{0, 1, 0, 16'h0000, 16'h0000}, '{2, 1, 0, 16'h0000, 16'hFFFF},
		'{2, 0, 0, 16'h0000, 16'h0000}};
	microprogram_address_sequencer uut (.core_clk(core_clk), .rstn(rstn), .srcSel(srcSel),
		.stackOp(stackOp), .condPass(condPass), .branchTaken(branchTaken), .regLoad(regLoad),
		.regDecr(regDecr), .directAddr(directAddr), .nextAddr(nextAddr), .regZero(regZero),
		.stackFull(stackFull), .stackEmpty(stackEmpty), .stackTop(stackTop));
	control_store_model store (.core_clk(core_clk), .addr(nextAddr), .pipeWord(pipeWord));
	always #5 core_clk = ~core_clk;
	// ********
	// drive and finish
	// ********
	task automatic drv(input logic [1:0] s, op, input logic c, b, ld, dc, input logic [15:0] d);
		@(posedge core_clk);
		srcSel <= seq_pkg::src_sel_t'(s);
		stackOp <= seq_pkg::stk_op_t'(op);
		condPass <= c;
		branchTaken <= b;
		regLoad <= ld;
		regDecr <= dc;
		directAddr <= d;
		@(negedge core_clk);
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish;
	end
	// ********
	// tests
	// ********
	initial begin
		repeat (5) @(posedge core_clk);
		rstn <= 1;
		@(negedge core_clk);
		`CHK("reset addr", 16'h0000, nextAddr)
		`CHK("reset flags", 3'b110, {stackEmpty, regZero, stackFull})
		for (int r = 0; r < 7; r++) begin
			drv(rows[r].s, 0, rows[r].c, 0, rows[r].ld, 0, rows[r].d);
			`CHK("addr", rows[r].e, nextAddr)
			if (r > 0)
				`CHK("word", {~rows[r-1].e, rows[r-1].e}, pipeWord)
		end
		// one extra push must be refused once the stack holds its full depth
		for (int i = 0; i < 34; i++)
			drv(1, 1, 1, 0, 0, 0, 16'(i));
		drv(0, 0, 1, 0, 0, 0, 0);
		`CHK("full", 1'b1, stackFull)
		for (int k = 0; k < 33; k++) begin
			drv(3, 2, 1, 0, 0, 0, 0);
			`CHK("pop", 16'(33 - k), nextAddr)
		end
		drv(0, 0, 1, 0, 0, 0, 0);
		`CHK("empty", 1'b1, stackEmpty)
		drv(1, 0, 1, 0, 0, 0, 16'h0200);
		drv(0, 1, 1, 1, 0, 0, 0);
		drv(3, 2, 1, 0, 0, 0, 0);
		`CHK("branch push", 16'h0201, nextAddr)
		`CHK("branch top", 16'h0201, stackTop)
		drv(0, 0, 1, 0, 1, 0, 16'h0002);
		for (int k = 0; k < 4; k++) begin
			drv(2, 0, 1, 0, 0, 1, 0);
			`CHK("count", (k < 2) ? 16'(2 - k) : 16'h0000, nextAddr)
		end
		`CHK("zero", 1'b1, regZero)
		drv(1, 1, 1, 0, 1, 0, 16'h0005);
		drv(0, 3, 1, 0, 0, 0, 0);
		drv(0, 0, 1, 0, 0, 0, 0);
		`CHK("clear", 1'b1, stackEmpty)
		// reset in mid-run must drop straight back to address zero
		@(posedge core_clk);
		rstn <= 0;
		#3;
		`CHK("mid reset", 16'h0000, nextAddr)
		@(posedge core_clk);
		rstn <= 1;
		@(negedge core_clk);
		`CHK("mid reset flags", 3'b110, {stackEmpty, regZero, stackFull})
		drv(0, 0, 1, 0, 0, 0, 0);
		`CHK("resume", 16'h0001, nextAddr)
		tally_and_finish;
	end
endmodule

// [src/microprogram_address_sequencer.sv]
// microprogram address sequencer: four-source next-address mux with
// incrementing address register, register/counter and a deep LIFO stack
// assumes the control store and pipeline register sit outside and that
// the microword decoder supplies source select, stack and counter controls
`timescale 1ns/1ns
module microprogram_address_sequencer #(
	parameter int ADDR_W = seq_pkg::ADDR_W,
	parameter int STACK_DEPTH = seq_pkg::STACK_DEPTH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// microword controls
	input wire seq_pkg::src_sel_t srcSel,
	input wire seq_pkg::stk_op_t stackOp,
	input wire logic condPass,
	input wire logic branchTaken,
	input wire logic regLoad,
	input wire logic regDecr,
	// direct input
	input wire logic [ADDR_W-1:0] directAddr,
	// address out to control store
	output logic [ADDR_W-1:0] nextAddr,
	// status
	output logic regZero,
	output logic stackFull,
	output logic stackEmpty,
	output logic [ADDR_W-1:0] stackTop
);
	localparam int PW = seq_pkg::PTR_W;

	// ************************************************************
	// state
	// ************************************************************
	logic [ADDR_W-1:0] counter_reg, counter_next;
	logic [ADDR_W-1:0] regCnt_reg, regCnt_next;
	logic [PW-1:0] depth_reg, depth_next;
	logic [ADDR_W-1:0] top_reg, top_next;
	logic [ADDR_W-1:0] addrMux;
	logic memWrEn;
	logic [PW-1:0] memWrAddr;
	logic [PW-1:0] memRdAddr;
	logic [ADDR_W-1:0] memRdData;
	logic popPending_reg, popPending_next;
	logic [ADDR_W-1:0] topLive;

	// ************************************************************
	// next-address selection
	// ************************************************************
	// a failed condition falls back to sequential flow
	always_comb begin
		addrMux = counter_reg;
		if (condPass) begin
			unique case (srcSel)
				seq_pkg::SRC_COUNTER: addrMux = counter_reg; // see RULE2
				seq_pkg::SRC_DIRECT: addrMux = directAddr; // see RULE7
				seq_pkg::SRC_REGCNT: addrMux = regCnt_reg; // see RULE4
				seq_pkg::SRC_STACK: addrMux = topLive; // see RULE6
			endcase
		end
	end
	assign nextAddr = addrMux; // see RULE1

	// ************************************************************
	// address register and register/counter
	// ************************************************************
	always_comb begin
		counter_next = addrMux + seq_pkg::ADDR_ONE; // see RULE3
		regCnt_next = regCnt_reg;
		if (regLoad) begin
			regCnt_next = directAddr; // see RULE4
		end else if (regDecr && regCnt_reg != seq_pkg::ADDR_RESET) begin
			regCnt_next = regCnt_reg - seq_pkg::ADDR_ONE;
		end
	end
	assign regZero = (regCnt_reg == seq_pkg::ADDR_RESET);

	// ************************************************************
	// stack: top lives in a register, deeper entries in memory
	// ************************************************************
	// memory read is registered, so a pop refills the top one cycle late
	assign topLive = popPending_reg ? memRdData : top_reg;
	assign stackFull = (depth_reg == PW'(STACK_DEPTH));
	assign stackEmpty = (depth_reg == seq_pkg::PTR_ZERO);

	always_comb begin
		depth_next = depth_reg;
		top_next = topLive;
		memWrEn = 1'b0;
		memWrAddr = depth_reg - seq_pkg::PTR_ONE;
		memRdAddr = depth_reg - PW'(2);
		popPending_next = 1'b0;
		unique case (stackOp)
			seq_pkg::STK_PUSH: begin
				// push of the return address, overflow is refused
				if (!stackFull) begin
					depth_next = depth_reg + seq_pkg::PTR_ONE; // see RULE5
					top_next = branchTaken ? counter_reg : counter_next;
					memWrEn = !stackEmpty;
				end
			end
			seq_pkg::STK_POP: begin
				if (!stackEmpty) begin
					depth_next = depth_reg - seq_pkg::PTR_ONE; // see RULE6
					popPending_next = (depth_reg > seq_pkg::PTR_ONE);
				end
			end
			seq_pkg::STK_CLEAR: begin
				depth_next = seq_pkg::PTR_ZERO;
			end
			seq_pkg::STK_HOLD: begin
				depth_next = depth_reg;
			end
		endcase
	end

	// old top goes down into memory at slot depth-1 on a push
	seq_stack_mem #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(ADDR_W),
		.PTR_W(PW)
	) u_mem (
		.core_clk(core_clk),
		.wrEn(memWrEn),
		.wrAddr(memWrAddr),
		.wrData(topLive),
		.rdAddr(memRdAddr),
		.rdData(memRdData)
	);
	assign stackTop = topLive;

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			counter_reg <= seq_pkg::ADDR_RESET;
			regCnt_reg <= seq_pkg::ADDR_RESET;
			depth_reg <= seq_pkg::PTR_ZERO;
			top_reg <= seq_pkg::ADDR_RESET;
			popPending_reg <= 1'b0;
		end else begin
			counter_reg <= counter_next; // see RULE8
			regCnt_reg <= regCnt_next;
			depth_reg <= depth_next;
			top_reg <= top_next;
			popPending_reg <= popPending_next;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	property p_increment;
		@(posedge core_clk) disable iff (!rstn)
		1'b1 |=> counter_reg == $past(nextAddr) + seq_pkg::ADDR_ONE;
	endproperty
	a_increment: assert property (p_increment) else $error("counter not addr+1"); // see RULE3

	property p_direct;
		@(posedge core_clk) disable iff (!rstn)
		(condPass && srcSel == seq_pkg::SRC_DIRECT) |-> nextAddr == directAddr;
	endproperty
	a_direct: assert property (p_direct) else $error("direct source not used"); // see RULE7

	property p_fail_seq;
		@(posedge core_clk) disable iff (!rstn)
		!condPass |-> nextAddr == counter_reg;
	endproperty
	a_fail_seq: assert property (p_fail_seq) else $error("failed cond not sequential"); // see RULE2

	property p_reg_hold;
		@(posedge core_clk) disable iff (!rstn)
		regLoad ##1 (!regLoad && !regDecr) |=> regCnt_reg == $past(directAddr, 2);
	endproperty
	a_reg_hold: assert property (p_reg_hold) else $error("register lost value"); // see RULE4

	sequence s_push_then_pop;
		(stackOp == seq_pkg::STK_PUSH && !stackFull) ##1 (stackOp == seq_pkg::STK_POP);
	endsequence
	property p_lifo;
		@(posedge core_clk) disable iff (!rstn)
		s_push_then_pop |=> depth_reg == $past(depth_reg, 2);
	endproperty
	a_lifo: assert property (p_lifo) else $error("push-pop depth mismatch"); // see RULE6

	property p_push_top;
		@(posedge core_clk) disable iff (!rstn)
		(stackOp == seq_pkg::STK_PUSH && !stackFull && !branchTaken)
			|=> stackTop == $past(nextAddr) + seq_pkg::ADDR_ONE;
	endproperty
	a_push_top: assert property (p_push_top) else $error("pushed top wrong"); // see RULE6

	property p_depth_cap;
		@(posedge core_clk) disable iff (!rstn)
		depth_reg <= PW'(STACK_DEPTH);
	endproperty
	a_depth_cap: assert property (p_depth_cap) else $error("stack over depth"); // see RULE5

	property p_full_hold;
		@(posedge core_clk) disable iff (!rstn)
		(stackFull && stackOp == seq_pkg::STK_PUSH) |=> stackFull;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("overflow changed depth"); // see RULE5

	property p_sync;
		@(posedge core_clk) disable iff (!rstn)
		(regLoad && stackOp == seq_pkg::STK_PUSH && !stackFull)
			|=> regCnt_reg == $past(directAddr) && !stackEmpty;
	endproperty
	a_sync: assert property (p_sync) else $error("state not updated together"); // see RULE8

	property p_regcnt_src;
		@(posedge core_clk) disable iff (!rstn)
		(condPass && srcSel == seq_pkg::SRC_REGCNT) |-> nextAddr == regCnt_reg;
	endproperty
	a_regcnt_src: assert property (p_regcnt_src) else $error("register source not used"); // see RULE4

	property p_reg_decr;
		@(posedge core_clk) disable iff (!rstn)
		(regDecr && !regLoad && !regZero)
			|=> regCnt_reg == $past(regCnt_reg) - seq_pkg::ADDR_ONE;
	endproperty
	a_reg_decr: assert property (p_reg_decr) else $error("register did not count down"); // see RULE4

	property p_pop_depth;
		@(posedge core_clk) disable iff (!rstn)
		(stackOp == seq_pkg::STK_POP && !stackEmpty)
			|=> depth_reg == $past(depth_reg) - seq_pkg::PTR_ONE;
	endproperty
	a_pop_depth: assert property (p_pop_depth) else $error("pop depth wrong"); // see RULE6

	property p_clear;
		@(posedge core_clk) disable iff (!rstn)
		stackOp == seq_pkg::STK_CLEAR |=> stackEmpty;
	endproperty
	a_clear: assert property (p_clear) else $error("clear left entries"); // see RULE5
endmodule

// [src/seq_pkg.sv]
// constants and types shared by the microprogram address sequencer
// assumes a single core clock and an active-low asynchronous reset
//
// Overview of operation
// RULE1: next address is sixteen bits wide, reaching a 64K-word control store.
// RULE2: each cycle the address comes from exactly one of four sources.
// RULE3: address register holds issued address plus one for sequential flow.
// RULE4: register/counter keeps an earlier loaded value for later address use.
// RULE5: a 33-entry stack holds return and loop addresses.
// RULE6: stack is last-in first-out; pop gives newest unpopped entry.
// RULE7: conditional branch may target any location in the full space.
// RULE8: all state updates together on the rising clock edge.
package seq_pkg;
	// ************************************************************
	// sizes
	// ************************************************************
	localparam int ADDR_W = 16;
	localparam int STACK_DEPTH = 33;
	localparam int PTR_W = 6;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
	localparam logic [PTR_W-1:0] PTR_ZERO = 6'h00;
	localparam logic [PTR_W-1:0] PTR_ONE = 6'h01;

	// ************************************************************
	// next-address source select
	// ************************************************************
	typedef enum logic [1:0] {
		SRC_COUNTER = 2'h0,
		SRC_DIRECT = 2'h1,
		SRC_REGCNT = 2'h2,
		SRC_STACK = 2'h3
	} src_sel_t;

	// stack action
	typedef enum logic [1:0] {
		STK_HOLD = 2'h0,
		STK_PUSH = 2'h1,
		STK_POP = 2'h2,
		STK_CLEAR = 2'h3
	} stk_op_t;
endpackage

// [src/seq_stack_mem.sv]
// storage array for the sequencer stack
// assumes the caller never writes and reads the same slot in one cycle
`timescale 1ns/1ns
module seq_stack_mem #(
	parameter int DEPTH = 33,
	parameter int WIDTH = 16,
	parameter int PTR_W = 6
) (
	// clock
	input wire logic core_clk,
	// write side
	input wire logic wrEn,
	input wire logic [PTR_W-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	// read side
	input wire logic [PTR_W-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [DEPTH];

	// no reset: contents are undefined until pushed
	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule
